// ===== inc/slcs_pkg.sv
// Shared constants and carrier types for the switch link configuration and status block.
package slcs_pkg;
  localparam int unsigned NLINK = 8;
  localparam int unsigned TOKEN_W = 9;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned SYM_W = 4;
  localparam int unsigned GAP_W = 11;

  // Register numbers of the node configuration space.
  localparam logic [7:0] REG_IDENT = 8'h00;
  localparam logic [7:0] REG_LSTAT_BASE = 8'h20;
  localparam logic [7:0] REG_PSTAT_BASE = 8'h40;
  localparam logic [7:0] REG_LCFG_BASE = 8'h80;
  localparam logic [7:0] REG_STATIC_BASE = 8'hA0;
  localparam logic [7:0] REG_BASE_MASK = 8'hF8;

  // Field positions of the link setup register and of the network field of the link status register.
  localparam int unsigned LCFG_EN_BIT = 31;
  localparam int unsigned LCFG_WIDE_BIT = 30;
  localparam int unsigned LCFG_ERR_BIT = 27;
  localparam int unsigned LCFG_RXCRED_BIT = 26;
  localparam int unsigned LCFG_TXCRED_BIT = 25;
  localparam int unsigned LCFG_LINK_GREETING_TOKEN_BIT = 24;
  localparam int unsigned LCFG_RXRST_BIT = 23;
  localparam int unsigned LCFG_SGAP_LSB = 11;
  localparam int unsigned LCFG_TGAP_LSB = 0;
  localparam int unsigned STAT_NET_LSB = 4;

  // Values after reset, and the settling count of the boot pins.
  localparam logic [GAP_W-1:0] GAP_RESET = 11'h000;
  localparam logic [1:0] NET_RESET = 2'h0;
  localparam logic [31:0] STATIC_RESET = 32'h0000_0000;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;

  // Control token sent to greet the remote end.
  localparam logic [TOKEN_W-1:0] GREETING_TOKEN = 9'h101;

  // Source target kinds.
  localparam logic [1:0] KIND_SWITCH_INTERNAL_LINK = 2'h0;
  localparam logic [1:0] KIND_PROCESSOR_LINK = 2'h1;
  localparam logic [1:0] KIND_SWITCH_CONTROL_PORT = 2'h2;

  // Events from a link's own receive and credit logic, one cycle each.
  typedef struct packed {
    logic grant_rx;
    logic credit_issued;
    logic rx_overflow;
    logic bad_token;
  } slcs_evt_t;

  // Routing state of a link as seen by the switch fabric.
  typedef struct packed {
    logic [1:0] source_target_kind;
    logic [7:0] dest;
    logic       junk;
    logic       dst_busy;
    logic       src_busy;
  } slcs_stat_t;

  // Transmit shaping of one link.
  typedef struct packed {
    logic             wide;
    logic [GAP_W-1:0] sym_gap;
    logic [GAP_W-1:0] tok_gap;
  } slcs_tx_cfg_t;
endpackage

// ===== verilog/slcs_fifo.sv
// Token FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module slcs_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // Handshakes and the occupancy that follows them.
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Pointers, count and registered full and empty flags.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != DEPTH[AW:0]);
      out_valid_o <= (cnt_d != '0);
    end
  end

  // Storage, written at the tail.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

// ===== verilog/slcs_tx_pacer.sv
// Token transmitter that splits tokens into symbols and keeps the idle gaps.
`timescale 1ns/100ps
module slcs_tx_pacer
  import slcs_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Setup.
  input  wire slcs_pkg::slcs_tx_cfg_t cfg_i,
  // Token offer.
  input  wire logic                 tok_valid_i,
  input  wire logic [TOKEN_W-1:0]   tok_data_i,
  output logic                      tok_take_o,
  // Symbol output.
  output logic                      sym_stb_o,
  output logic                      sym_ctl_o,
  output logic      [SYM_W-1:0]     sym_o
);
  typedef enum logic [1:0] {IDLE, SEND, SGAP, TGAP} slcs_pace_t;

  slcs_pace_t       st_q;
  logic [GAP_W-1:0] gap_q;
  logic [7:0]       sh_q;
  logic [1:0]       left_q;

  assign tok_take_o = (st_q == IDLE) & tok_valid_i;

  // Sequencing of symbols, symbol gaps and token gaps.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= IDLE;
      gap_q <= GAP_RESET;
      sh_q <= 8'h00;
      left_q <= 2'h0;
      sym_stb_o <= 1'b0;
      sym_ctl_o <= 1'b0;
      sym_o <= 4'h0;
    end else begin
      sym_stb_o <= 1'b0;
      unique case (st_q)
        IDLE: begin
          if (tok_valid_i) begin
            sh_q <= tok_data_i[7:0];
            sym_ctl_o <= tok_data_i[8];
            left_q <= cfg_i.wide ? 2'h1 : 2'h3;
            st_q <= SEND;
          end
        end
        SEND: begin
          sym_stb_o <= 1'b1;
          sym_o <= cfg_i.wide ? sh_q[3:0] : {2'h0, sh_q[1:0]};
          sh_q <= cfg_i.wide ? {4'h0, sh_q[7:4]} : {2'h0, sh_q[7:2]};
          if (left_q == 2'h0) begin
            gap_q <= cfg_i.tok_gap;
            st_q <= TGAP;
          end else begin
            left_q <= left_q - 1'b1;
            gap_q <= cfg_i.sym_gap;
            st_q <= SGAP;
          end
        end
        SGAP: begin
          if (gap_q == GAP_RESET) begin
            st_q <= SEND;
          end else begin
            gap_q <= gap_q - 1'b1;
          end
        end
        TGAP: begin
          if (gap_q == GAP_RESET) begin
            st_q <= IDLE;
          end else begin
            gap_q <= gap_q - 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// ===== verilog/slcs_top.sv
// Configuration and status registers of the external switch links, with the link 0 transmitter.
`timescale 1ns/100ps
// Operation
// - Writing bit 31 of a link setup register enables or disables that link.
// - The same enable bit drives that link's LINK_EN_O output; on link 0 it also gates the token path.
// - Wire-mode bit, reset zero, picks two wires when clear, five when set.
// - Error flag sets on receive overflow or an illegally encoded token.
// - Read-only flag, reset zero, shows this end has issued credit.
// - Read-only flag, reset zero, shows this end holds transmit credit.
// - Command bit clears transmit credit and sends a greeting token; remote grants credit.
// - Command bit resets the receiver so the next symbol starts a token.
// - Eleven-bit field, reset zero, sets least idle clocks between symbols, minus one.
// - Eleven-bit field, reset zero, sets least idle clocks between tokens, minus two.
// - One link setup register per external link, links zero to seven.
// - Two-bit field reports source target kind of the link.
// - Eight-bit field shows the destination link while the link is in use.
// - Two-bit read-write field, reset zero, selects the link's network.
// - Status bit reads one while the current packet is junk.
// - Status bit reads one while the destination side is in use.
// - Status bit reads one while the source side is in use.
// - Identity register holds boot control pins captured at power-on reset.
// - Identity register reports switch revision and version.
// - All registers reached by configuration reads and writes by register number.
module slcs_top
  import slcs_pkg::*;
#(
  parameter logic [7:0] SWITCH_REVISION = 8'h01, // Arbitrary value.
  parameter logic [7:0] SWITCH_VERSION  = 8'h01  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                         MCLK_I,
  input  wire logic                         RST_N_I,
  // Configuration access by register number.
  input  wire logic                         CFG_WR_I,
  input  wire logic                         CFG_RD_I,
  input  wire logic [7:0]                   CFG_ADDR_I,
  input  wire logic [31:0]                  CFG_WDATA_I,
  output logic      [31:0]                  CFG_RDATA_O,
  output logic                              CFG_RVALID_O,
  // Boot control pins.
  input  wire logic [7:0]                   BOOT_CONTROL_PINS_I,
  // Per-link events and routing state.
  input  wire slcs_pkg::slcs_evt_t  [NLINK-1:0] LINK_EVT_I,
  input  wire slcs_pkg::slcs_stat_t [NLINK-1:0] LINK_STAT_I,
  // Per-link control.
  output logic      [NLINK-1:0]             LINK_EN_O,
  output logic      [NLINK-1:0]             LINK_WIDE_O,
  output logic      [NLINK-1:0]             LINK_GREET_O,
  output logic      [NLINK-1:0]             LINK_RXRST_O,
  // Link 0 token source.
  input  wire logic                         TX_TOK_VALID_I,
  input  wire logic [TOKEN_W-1:0]           TX_TOK_DATA_I,
  output logic                              TX_TOK_READY_O,
  // Link 0 symbol output.
  output logic                              TX_SYM_STB_O,
  output logic                              TX_SYM_CTL_O,
  output logic      [SYM_W-1:0]             TX_SYM_O
);
  import slcs_pkg::*;

  logic [GAP_W-1:0]   sym_gap_q [NLINK];
  logic [GAP_W-1:0]   tok_gap_q [NLINK];
  logic [1:0]         net_q [NLINK];
  logic [31:0]        static_q [NLINK];
  logic [NLINK-1:0]   tx_cred_q;
  logic [NLINK-1:0]   rx_cred_q;
  logic [NLINK-1:0]   rx_err_q;
  logic [7:0]         boot_s1_q;
  logic [7:0]         boot_s2_q;
  logic [7:0]         boot_s3_q;
  logic [7:0]         boot_q;
  logic [1:0]         boot_cnt_q;
  logic               boot_done_q;
  logic               greet_pend_q;
  logic [2:0]         idx;
  logic               wr_lcfg;
  logic               wr_net;
  logic               wr_static;
  logic [31:0]        rdata_d;
  logic               fifo_valid;
  logic               fifo_ready;
  logic [TOKEN_W-1:0] fifo_data;
  logic               tok_valid;
  logic [TOKEN_W-1:0] tok_data;
  logic               tok_take;
  slcs_tx_cfg_t       tx_cfg;

  // Matches a register number against an eight-entry bank.
  function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
    in_bank = ((addr & REG_BASE_MASK) == base);
  endfunction

  // Builds the link state word shared by both status banks.
  function automatic logic [31:0] stat_word(input slcs_stat_t s, input logic [1:0] net);
    stat_word = {6'h00, s.source_target_kind, s.dest, 10'h000, net, 1'b0, s.junk, s.dst_busy, s.src_busy};
  endfunction

  // Write decode by register number; the low three bits pick the link.
  assign idx = CFG_ADDR_I[2:0];
  assign wr_lcfg = CFG_WR_I & in_bank(CFG_ADDR_I, REG_LCFG_BASE);
  assign wr_net = CFG_WR_I & (in_bank(CFG_ADDR_I, REG_LSTAT_BASE) | in_bank(CFG_ADDR_I, REG_PSTAT_BASE));
  assign wr_static = CFG_WR_I & in_bank(CFG_ADDR_I, REG_STATIC_BASE);

  // Boot pins pass three flops, then are caught once after reset release when the last two agree.
  always_ff @(posedge MCLK_I) begin
    boot_s1_q <= BOOT_CONTROL_PINS_I;
    boot_s2_q <= boot_s1_q;
    boot_s3_q <= boot_s2_q;
  end

  // Capture of the boot pins into the identity register.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      boot_cnt_q <= 2'h0;
      boot_done_q <= 1'b0;
      boot_q <= 8'h00;
    end else if (!boot_done_q) begin
      if (boot_cnt_q != BOOT_SETTLE) begin
        boot_cnt_q <= boot_cnt_q + 1'b1;
      end else if (boot_s2_q == boot_s3_q) begin
        boot_q <= boot_s3_q;
        boot_done_q <= 1'b1;
      end
    end
  end

  // Link setup fields: enable, wire mode and the two gap settings.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      LINK_EN_O <= '0;
      LINK_WIDE_O <= '0;
      for (int i = 0; i < NLINK; i++) begin
        sym_gap_q[i] <= GAP_RESET;
        tok_gap_q[i] <= GAP_RESET;
      end
    end else if (wr_lcfg) begin
      LINK_EN_O[idx] <= CFG_WDATA_I[LCFG_EN_BIT];
      LINK_WIDE_O[idx] <= CFG_WDATA_I[LCFG_WIDE_BIT];
      sym_gap_q[idx] <= CFG_WDATA_I[LCFG_SGAP_LSB +: GAP_W];
      tok_gap_q[idx] <= CFG_WDATA_I[LCFG_TGAP_LSB +: GAP_W];
    end
  end

  // Network select and static setup words.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < NLINK; i++) begin
        net_q[i] <= NET_RESET;
        static_q[i] <= STATIC_RESET;
      end
    end else begin
      if (wr_net) begin
        net_q[idx] <= CFG_WDATA_I[STAT_NET_LSB +: 2];
      end
      if (wr_static) begin
        static_q[idx] <= CFG_WDATA_I;
      end
    end
  end

  // One-cycle greeting and receiver reset commands to each link.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      LINK_GREET_O <= '0;
      LINK_RXRST_O <= '0;
    end else begin
      LINK_GREET_O <= '0;
      LINK_RXRST_O <= '0;
      if (wr_lcfg) begin
        LINK_GREET_O[idx] <= CFG_WDATA_I[LCFG_LINK_GREETING_TOKEN_BIT];
        LINK_RXRST_O[idx] <= CFG_WDATA_I[LCFG_RXRST_BIT];
      end
    end
  end

  // Credit and error flags; an event in the clearing cycle wins.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      tx_cred_q <= '0;
      rx_cred_q <= '0;
      rx_err_q <= '0;
    end else begin
      for (int i = 0; i < NLINK; i++) begin
        if (LINK_EVT_I[i].grant_rx) begin
          tx_cred_q[i] <= 1'b1;
        end else if (wr_lcfg && idx == i[2:0] && CFG_WDATA_I[LCFG_LINK_GREETING_TOKEN_BIT]) begin
          tx_cred_q[i] <= 1'b0;
        end
        if (LINK_EVT_I[i].credit_issued) begin
          rx_cred_q[i] <= 1'b1;
        end else if (wr_lcfg && idx == i[2:0] && CFG_WDATA_I[LCFG_RXRST_BIT]) begin
          rx_cred_q[i] <= 1'b0;
        end
        if (LINK_EVT_I[i].rx_overflow | LINK_EVT_I[i].bad_token) begin
          rx_err_q[i] <= 1'b1;
        end else if (wr_lcfg && idx == i[2:0] && CFG_WDATA_I[LCFG_RXRST_BIT]) begin
          rx_err_q[i] <= 1'b0;
        end
      end
    end
  end

  // Read mux; command, reserved and unmapped bits read zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (CFG_ADDR_I == REG_IDENT) begin
      rdata_d = {8'h00, boot_q, SWITCH_REVISION, SWITCH_VERSION};
    end else if (in_bank(CFG_ADDR_I, REG_LSTAT_BASE) || in_bank(CFG_ADDR_I, REG_PSTAT_BASE)) begin
      rdata_d = stat_word(LINK_STAT_I[idx], net_q[idx]);
    end else if (in_bank(CFG_ADDR_I, REG_LCFG_BASE)) begin
      rdata_d = {LINK_EN_O[idx], LINK_WIDE_O[idx], 2'h0, rx_err_q[idx], rx_cred_q[idx], tx_cred_q[idx],
                 3'h0, sym_gap_q[idx], tok_gap_q[idx]};
    end else if (in_bank(CFG_ADDR_I, REG_STATIC_BASE)) begin
      rdata_d = static_q[idx];
    end
  end

  // Read answer one cycle after the request.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CFG_RDATA_O <= 32'h0000_0000;
      CFG_RVALID_O <= 1'b0;
    end else begin
      CFG_RVALID_O <= CFG_RD_I;
      if (CFG_RD_I) begin
        CFG_RDATA_O <= rdata_d;
      end
    end
  end

  // Link 0 greeting waits here until the transmitter takes it.
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      greet_pend_q <= 1'b0;
    end else if (wr_lcfg && idx == 3'h0 && CFG_WDATA_I[LCFG_LINK_GREETING_TOKEN_BIT]) begin
      greet_pend_q <= 1'b1;
    end else if (tok_take) begin
      greet_pend_q <= 1'b0;
    end
  end

  // Greeting goes ahead of data and needs no credit; data needs credit and an enabled link.
  assign tok_valid = LINK_EN_O[0] & (greet_pend_q | (fifo_valid & tx_cred_q[0]));
  assign tok_data = greet_pend_q ? GREETING_TOKEN : fifo_data;
  assign fifo_ready = tok_take & ~greet_pend_q;
  assign tx_cfg = '{wide: LINK_WIDE_O[0], sym_gap: sym_gap_q[0], tok_gap: tok_gap_q[0]};

  // Token buffer in front of the link 0 transmitter.
  slcs_fifo #(
    .WIDTH (TOKEN_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (MCLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (TX_TOK_VALID_I),
    .in_ready_o  (TX_TOK_READY_O),
    .in_data_i   (TX_TOK_DATA_I),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  // Symbol sequencer of link 0.
  slcs_tx_pacer u_pacer (
    .clk_i       (MCLK_I),
    .rst_n_i     (RST_N_I),
    .cfg_i       (tx_cfg),
    .tok_valid_i (tok_valid),
    .tok_data_i  (tok_data),
    .tok_take_o  (tok_take),
    .sym_stb_o   (TX_SYM_STB_O),
    .sym_ctl_o   (TX_SYM_CTL_O),
    .sym_o       (TX_SYM_O)
  );

  // Checks on the register behaviour.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  // Setup fields follow each write.
  enable_write_a: assert property (wr_lcfg |=> LINK_EN_O[$past(idx)] == $past(CFG_WDATA_I[LCFG_EN_BIT]))
    else $error("link enable did not follow the write");

  wire_mode_a: assert property (wr_lcfg |=> LINK_WIDE_O[$past(idx)] == $past(CFG_WDATA_I[LCFG_WIDE_BIT]))
    else $error("wire mode did not follow the write");

  net_write_a: assert property (wr_net |=> net_q[$past(idx)] == $past(CFG_WDATA_I[STAT_NET_LSB +: 2]))
    else $error("network select did not follow the write");

  // A greeting gives one pulse, clears credit and goes ahead of data.
  greet_pulse_a: assert property (wr_lcfg && CFG_WDATA_I[LCFG_LINK_GREETING_TOKEN_BIT] |=> LINK_GREET_O[$past(idx)])
    else $error("greeting command gave no pulse");

  greet_credit_a: assert property (wr_lcfg && CFG_WDATA_I[LCFG_LINK_GREETING_TOKEN_BIT] && !LINK_EVT_I[idx].grant_rx
                                   |=> !tx_cred_q[$past(idx)])
    else $error("greeting did not clear transmit credit");

  greet_first_a: assert property (greet_pend_q && tok_take |-> ##2 TX_SYM_STB_O && TX_SYM_CTL_O
      && TX_SYM_O == ($past(LINK_WIDE_O[0]) ? GREETING_TOKEN[3:0]
                                            : {2'h0, GREETING_TOKEN[1:0]}))
    else $error("greeting token lost its place");

  // Flags follow their events.
  tx_credit_a: assert property (LINK_EVT_I[0].grant_rx |=> tx_cred_q[0])
    else $error("grant gave no transmit credit");

  rx_credit_a: assert property (LINK_EVT_I[7].credit_issued |=> rx_cred_q[7])
    else $error("issued credit not flagged");

  error_set_a: assert property (LINK_EVT_I[0].rx_overflow || LINK_EVT_I[0].bad_token |=> rx_err_q[0])
    else $error("receive error flag not set");

  rxrst_clear_a: assert property (wr_lcfg && idx == 3'h0 && CFG_WDATA_I[LCFG_RXRST_BIT]
                                  && !LINK_EVT_I[0].rx_overflow && !LINK_EVT_I[0].bad_token
                                  |=> !rx_err_q[0] && LINK_RXRST_O[0]
      ##1 (!LINK_RXRST_O[0] || $past(wr_lcfg && idx == 3'h0 && CFG_WDATA_I[LCFG_RXRST_BIT])))
    else $error("receiver reset misbehaved");

  // Reads answer in one cycle with command bits zero; captured boot pins hold.
  read_answer_a: assert property (CFG_RD_I |=> CFG_RVALID_O)
    else $error("read got no answer");

  cmd_reads_zero_a: assert property (CFG_RD_I && in_bank(CFG_ADDR_I, REG_LCFG_BASE)
                                     |=> CFG_RDATA_O[LCFG_LINK_GREETING_TOKEN_BIT] == 1'b0 && CFG_RDATA_O[LCFG_RXRST_BIT] == 1'b0)
    else $error("command bits read back nonzero");

  boot_stable_a: assert property (boot_done_q |=> $stable(boot_q))
    else $error("captured boot pins changed");

  // The token path keeps credit and idle clocks.
  data_credit_a: assert property (fifo_ready |-> tx_cred_q[0] && LINK_EN_O[0])
    else $error("data sent without credit");

  sym_idle_a: assert property (TX_SYM_STB_O |=> !TX_SYM_STB_O)
    else $error("symbols sent without an idle clock");

  // Covers mark the main scenarios.
  greet_sent_c: cover property (greet_pend_q && tok_take);
  fifo_full_c: cover property (!TX_TOK_READY_O && TX_TOK_VALID_I);
  data_sent_c: cover property (fifo_ready ##[1:40] TX_SYM_STB_O);
  two_wire_c: cover property (TX_SYM_STB_O && !LINK_WIDE_O[0]);
  credit_grant_c: cover property (LINK_GREET_O[0] ##[1:300] tx_cred_q[0]);
endmodule

// ===== testbench/slcs_remote_end.sv
// Remote link end that rebuilds link 0 tokens and answers a greeting with credit.
`timescale 1ns/100ps
module slcs_remote_end
  import slcs_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Symbols from the link and answer delay.
  input  wire logic               stb_i,
  input  wire logic               ctl_i,
  input  wire logic               wide_i,
  input  wire logic [SYM_W-1:0]   sym_i,
  input  wire logic [10:0]        dly_i,
  // Rebuilt tokens and credit grant.
  output logic                    tok_stb_o,
  output logic [TOKEN_W-1:0]      tok_o,
  output logic                    grant_o
);
  logic [7:0]  acc_d;
  logic [7:0]  acc_q;
  logic [2:0]  cnt_q;
  logic [11:0] wait_q;
  // The low symbol comes first, so each new symbol enters at the top.
  assign acc_d = wide_i ? {sym_i, acc_q[7:4]} : {sym_i[1:0], acc_q[7:2]};
  // Token assembly; a greeting starts a countdown that ends in one grant pulse.
  always_ff @(posedge clk_i) begin
    tok_stb_o <= 1'b0;
    grant_o   <= (wait_q == 12'h001);
    if (wait_q != 12'h000) wait_q <= wait_q - 12'h001;
    if (!rst_n_i) begin
      cnt_q  <= 3'h0;
      wait_q <= 12'h000;
    end else if (stb_i) begin
      acc_q <= acc_d;
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == (wide_i ? 3'h1 : 3'h3)) begin
        cnt_q     <= 3'h0;
        tok_stb_o <= 1'b1;
        tok_o     <= {ctl_i, acc_d};
        if ({ctl_i, acc_d} == GREETING_TOKEN) wait_q <= {1'b0, dly_i} + 12'h001;
      end
    end
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the switch link configuration and status block.
`timescale 1ns/100ps
module tb;
  import slcs_pkg::*;
  localparam logic [7:0] REV = 8'h5A;  // Arbitrary value.
  localparam logic [7:0] VER = 8'hC3;  // Arbitrary value.
  logic                   mclk, rst_n, cfg_wr, cfg_rd, rvalid, tok_valid, tok_ready, sym_stb, sym_ctl, tok_stb, grant;
  logic [7:0]             cfg_addr, boot, a;
  logic [31:0]            wdata, rdata, d, cfg [NLINK];
  logic [15:0]            pulses;
  logic [TOKEN_W-1:0]     tok_data, rx_tok;
  logic [SYM_W-1:0]       sym;
  logic [10:0]            dly;
  logic [NLINK-1:0]       en, wide, greet, rxrst;
  slcs_evt_t  [NLINK-1:0] evt, evt_w;
  slcs_stat_t [NLINK-1:0] stat;
  logic [31:0]            rdq [$];
  logic [TOKEN_W-1:0]     tokq [$];
  int                     errors, n_tests, n;

  // Free-running system clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // The remote end's grant joins the link 0 events.
  always_comb begin
    evt_w = evt;
    evt_w[0].grant_rx = evt[0].grant_rx | grant;
  end

  slcs_top #(.SWITCH_REVISION(REV), .SWITCH_VERSION(VER)) u_slcs_top (
    .MCLK_I(mclk), .RST_N_I(rst_n), .CFG_WR_I(cfg_wr), .CFG_RD_I(cfg_rd), .CFG_ADDR_I(cfg_addr),
    .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .BOOT_CONTROL_PINS_I(boot),
    .LINK_EVT_I(evt_w), .LINK_STAT_I(stat), .LINK_EN_O(en), .LINK_WIDE_O(wide), .LINK_GREET_O(greet),
    .LINK_RXRST_O(rxrst), .TX_TOK_VALID_I(tok_valid), .TX_TOK_DATA_I(tok_data), .TX_TOK_READY_O(tok_ready),
    .TX_SYM_STB_O(sym_stb), .TX_SYM_CTL_O(sym_ctl), .TX_SYM_O(sym));

  slcs_remote_end u_slcs_remote_end (
    .clk_i(mclk), .rst_n_i(rst_n), .stb_i(sym_stb), .ctl_i(sym_ctl), .wide_i(wide[0]), .sym_i(sym),
    .dly_i(dly), .tok_stb_o(tok_stb), .tok_o(rx_tok), .grant_o(grant));

  // Counts a comparison and reports a difference.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One configuration access; a read notes its expected answer, pulses are caught one cycle on.
  task automatic acc(input logic w, input logic r, input logic [7:0] ad, input logic [31:0] wd, input logic [31:0] e);
    cfg_wr   = w;
    cfg_rd   = r;
    cfg_addr = ad;
    wdata    = wd;
    if (r) rdq.push_back(e);
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    pulses = {greet, rxrst};
    @(negedge mclk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    acc(1'b0, 1'b1, ad, 32'h0, e);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    acc(1'b1, 1'b0, ad, wd, 32'h0);
  endtask

  // One-cycle event pulse on one link.
  task automatic pulse(input int i, input logic [3:0] e);
    evt[i] = e;
    @(negedge mclk);
    evt[i] = 4'h0;
    @(negedge mclk);
  endtask

  // Offers tokens while the FIFO accepts them, noting each one.
  task automatic fill(input int lim, output int cnt);
    cnt = 0;
    while (tok_ready === 1'b1 && cnt < lim) begin
      tok_valid = 1'b1;
      tok_data  = 9'($urandom());
      if (tok_data == GREETING_TOKEN) tok_data = 9'h0FF;
      tokq.push_back(tok_data);
      cnt++;
      @(negedge mclk);
    end
    tok_valid = 1'b0;
  endtask

  // Waits, bounded, until the remote end has seen every noted token.
  task automatic drain();
    for (int k = 0; k < 3000 && tokq.size() != 0; k++) @(negedge mclk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Every read answer and every rebuilt token is compared with the oldest note.
  always @(negedge mclk) begin
    if (rvalid === 1'b1) chk("read data", rdata, (rdq.size() != 0) ? rdq.pop_front() : 32'hDEAD_BEEF);
    if (tok_stb === 1'b1) chk("token", 32'(rx_tok), (tokq.size() != 0) ? 32'(tokq.pop_front()) : 32'hFFFF);
  end

  // Cuts a hang short far beyond the expected run of under 700 cycles.
  initial begin
    #1000000;
    errors++;
    stop_test();
  end

  initial begin
    slcs_stat_t s;
    void'($urandom(32'h3150));
    {cfg_wr, cfg_rd, tok_valid, cfg_addr, wdata, tok_data, dly} = '0;
    evt   = '0;
    stat  = '0;
    boot  = 8'($urandom());
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < NLINK; i++) begin
      rd(REG_LCFG_BASE | 8'(i), 32'h0);
      rd(REG_LSTAT_BASE | 8'(i), 32'h0);
      rd(REG_STATIC_BASE | 8'(i), STATIC_RESET);
    end
    rd(REG_IDENT, {8'h00, boot, REV, VER});
    rd(8'h28, 32'h0);
    d = $urandom();
    wr(REG_STATIC_BASE | 8'h03, d);
    rd(REG_STATIC_BASE | 8'h03, d);
    $display("test reset and identity done");
    for (int i = 0; i < NLINK; i++) begin
      d = $urandom() | 32'h0180_0000;
      if (i == 0) d = d & 32'h7EFF_FFFF;
      cfg[i] = d & 32'hC03F_FFFF;
      wr(REG_LCFG_BASE | 8'(i), d);
      chk("enable", 32'(en[i]), 32'(d[31]));
      chk("wide", 32'(wide[i]), 32'(d[30]));
      chk("commands", 32'(pulses), 32'({8'(d[24]) << i, 8'h01 << i}));
      rd(REG_LCFG_BASE | 8'(i), cfg[i]);
    end
    $display("test link setup done");
    for (int i = 1; i < NLINK; i++) begin
      a = REG_LCFG_BASE | 8'(i);
      pulse(i, 4'hE);
      rd(a, cfg[i] | 32'h0E00_0000);
      wr(a, cfg[i] | 32'h0100_0000);
      rd(a, cfg[i] | 32'h0C00_0000);
      wr(a, cfg[i] | 32'h0080_0000);
      rd(a, cfg[i]);
      pulse(i, 4'h1);
      rd(a, cfg[i] | 32'h0800_0000);
      wr(a, cfg[i] | 32'h0080_0000);
    end
    $display("test link events done");
    for (int i = 0; i < NLINK; i++) begin
      s = 13'($urandom());
      s.source_target_kind = 2'(i);
      stat[i] = s;
      d = $urandom();
      wr(REG_PSTAT_BASE | 8'(i), d);
      d = {6'h0, s.source_target_kind, s.dest, 10'h0, d[5:4], 1'b0, s.junk, s.dst_busy, s.src_busy};
      rd(REG_LSTAT_BASE | 8'(i), d);
      rd(REG_PSTAT_BASE | 8'(i), d);
    end
    $display("test link state done");
    fill(40, n);
    chk("fifo depth", 32'(n), FIFO_DEPTH);
    tokq.push_front(GREETING_TOKEN);
    dly = 11'h001;
    d = 32'hC100_0000 | ($urandom() & 32'h0000_1803);
    wr(REG_LCFG_BASE, d);
    drain();
    rd(REG_LCFG_BASE, (d & 32'hC03F_FFFF) | 32'h0200_0000);
    tokq.push_back(GREETING_TOKEN);
    dly = 11'h028;
    wr(REG_LCFG_BASE, 32'h8100_0000 | ($urandom() & 32'h0000_1803));
    fill(6, n);
    drain();
    repeat (4) @(negedge mclk);
    chk("pending notes", 32'(rdq.size() + tokq.size()), 32'h0);
    $display("test token path done");
    stop_test();
  end
endmodule
